// ---- src/sfd_top.sv ----
// Purpose: per-frame final activity decision and transmission hangover
// Assumes: one frame_valid_i pulse per frame; features stable while it is high
// Notes:   registers over apb; excitation samples stream in before the strobe
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module sfd_top
   import sfd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        frame_valid_i,
   input  wire sfd_feat_t   feat_i,
   input  wire logic        exc_valid_i,
   input  wire logic [15:0] exc_sample_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output sfd_res_t         res_o
);
   // ************************************************************
   // register file
   // ************************************************************
   logic [7:0]  ctrl_ff;
   logic [15:0] thr1_ff;
   logic [15:0] thr2_ff;
   logic [15:0] cn_tol_ff;
   logic [15:0] exc_log_ff;
   logic [3:0]  ho_len_ff;
   logic [3:0]  general_hangover_counter_ff;
   logic [3:0]  transmission_hangover_counter_ff;
   logic [3:0]  music_hangover_counter_ff;
   logic        apb_access;
   logic        addr_ok;
   sfd_rate_t   rate;
   sfd_bw_t     bw;

   assign apb_access = psel_i & penable_i & ~pready_o;
   assign addr_ok = (paddr_i == SFD_CTRL_OFS) || (paddr_i == SFD_THR_OFS) ||
                    (paddr_i == SFD_STATUS_OFS) || (paddr_i == SFD_COUNT_OFS) ||
                    (paddr_i == SFD_CNENERGY_OFS);
   assign rate = sfd_rate_t'(ctrl_ff[SFD_CTRL_RATE_LSB +: 2]);
   assign bw   = sfd_bw_t'(ctrl_ff[SFD_CTRL_BW_LSB +: 2]);

   // one wait state: answer lands in the cycle after setup+access start
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0;
      end else begin
         pready_o  <= apb_access;
         pslverr_o <= apb_access & ~addr_ok;
         if (apb_access & ~pwrite_i) begin
            unique case (paddr_i)
               SFD_CTRL_OFS:     prdata_o <= {24'h0, ctrl_ff};
               SFD_THR_OFS:      prdata_o <= {thr2_ff, thr1_ff};
               SFD_STATUS_OFS:   prdata_o <= {27'h0, res_o};
               SFD_COUNT_OFS:    prdata_o <= {16'h0, ho_len_ff,
                                    music_hangover_counter_ff, transmission_hangover_counter_ff,
                                    general_hangover_counter_ff};
               SFD_CNENERGY_OFS: prdata_o <= {cn_tol_ff, exc_log_ff};
               default:          prdata_o <= 32'h0;
            endcase
         end
      end
   end

   // writes land at the edge where the master sees ready; init bit self-clears
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_ff   <= SFD_CTRL_RST;
         thr1_ff   <= SFD_THR1_RST;
         thr2_ff   <= SFD_THR2_RST;
         cn_tol_ff <= SFD_CN_TOL_RST;
      end else begin
         if (frame_valid_i) begin
            ctrl_ff[SFD_CTRL_INIT_BIT] <= 1'b0;
         end
         if (psel_i & penable_i & pready_o & pwrite_i) begin
            unique case (paddr_i)
               SFD_CTRL_OFS:     ctrl_ff <= pwdata_i[7:0];
               SFD_THR_OFS: begin
                  thr1_ff <= pwdata_i[15:0];
                  thr2_ff <= pwdata_i[31:16];
               end
               SFD_CNENERGY_OFS: cn_tol_ff <= pwdata_i[31:16];
               default:          ;
            endcase
         end
      end
   end

   // ************************************************************
   // excitation energy
   // ************************************************************
   logic [39:0] exc_acc_ff;
   logic [39:0] mean_sq;

   function automatic logic [15:0] log2_q4(input logic [39:0] v);
      logic [15:0] r;
      logic [5:0]  msb;
      r = 16'h0;
      msb = 6'h0;
      for (int i = 0; i < 40; i++) begin
         if (v[i]) begin
            msb = 6'(i);
         end
      end
      // integer part plus the next four bits below the leading one as fraction
      r[9:4] = msb;
      if (msb >= 6'h4) begin
         r[3:0] = 4'(v >> (msb - 6'h4));
      end
      return r;
   endfunction

   // frame length is a power of two, so the mean is a shift
   assign mean_sq = exc_acc_ff >> $clog2(SFD_FRAME_LEN);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         exc_acc_ff <= 40'h0;
         exc_log_ff <= 16'h0;
      end else if (frame_valid_i) begin
         exc_log_ff <= log2_q4(mean_sq);
         exc_acc_ff <= 40'h0;
      end else if (exc_valid_i) begin
         exc_acc_ff <= exc_acc_ff + 40'(32'($signed(exc_sample_i) * $signed(exc_sample_i)));
      end
   end

   // ************************************************************
   // combined decision
   // ************************************************************
   logic silence;
   logic combined;
   logic pf;
   logic sf;
   logic or_cond_hi;
   logic or_cond_lo;

   assign pf = feat_i.primary_activity_flag;
   assign sf = feat_i.secondary_activity_flag;
   assign silence = (feat_i.original_longterm_snr > thr1_ff) &&
                    (feat_i.smoothed_longterm_freq_snr > thr2_ff);
   assign or_cond_hi = (feat_i.avg_snr_flux > SFD_FLUX_2P2) ||
                       ((feat_i.avg_snr_flux > SFD_FLUX_1P5) &&
                        (feat_i.consecutive_active_count > SFD_CONT_40)) ||
                       feat_i.tonal_flag;
   assign or_cond_lo = (feat_i.avg_snr_flux > SFD_FLUX_2P0) ||
                       ((feat_i.avg_snr_flux > SFD_FLUX_1P5) &&
                        (feat_i.consecutive_active_count > SFD_CONT_30)) ||
                       feat_i.tonal_flag;

   // steps evaluated in priority order, first match wins
   always_comb begin
      combined = sf;
      if (rate == SFD_RATE_16K || rate == SFD_RATE_32K) begin
         if (silence && feat_i.freq_snr > SFD_SNRF_0P2 && !sf) begin
            combined = pf;
         end else if (!(feat_i.smoothed_longterm_freq_snr < SFD_LF_10P5 || !silence)) begin
            combined = sf;
         end else if (or_cond_hi) begin
            combined = pf | sf;
         end else if (rate == SFD_RATE_32K) begin
            combined = silence ? pf : sf;
         end else begin
            combined = pf;
         end
      end else if (silence) begin
         if (feat_i.smoothed_longterm_freq_snr > SFD_LF_12P5 && !feat_i.tonal_flag) begin
            combined = pf;
         end
      end else if (or_cond_lo) begin
         combined = pf | sf;
      end
   end

   // ************************************************************
   // transmission hangover
   // ************************************************************
   logic [3:0] ho_len;
   logic [3:0] dec;
   logic [1:0] run_ff;
   logic       restart;
   logic       music_start;
   logic       cn_close;
   logic [15:0] cn_diff;
   logic       in_hang;
   logic       tx_flag;
   logic       sid_pend_ff;

   always_comb begin
      ho_len = SFD_HO_BASE;
      if ((bw == SFD_BW_NB && feat_i.longterm_snr < SFD_LT_16) ||
          feat_i.primary_high_energy_activity > SFD_HE_0P95) begin
         ho_len = SFD_HO_BASE_NB;
      end
      if (feat_i.primary_active_count16 > SFD_C16_12) begin
         ho_len = ho_len + SFD_HO_ADD16;
      end
      if (feat_i.final_active_count50 > SFD_C50_40) begin
         ho_len = ho_len + SFD_HO_ADD50;
      end
      if (ho_len > SFD_HANGOVER_LONG - 4'h1) begin
         ho_len = SFD_HANGOVER_LONG - 4'h1;
      end
      if (feat_i.primary_active_count16 < SFD_C16_7 ||
          (feat_i.longterm_snr > SFD_LT_16 &&
           feat_i.primary_high_energy_activity < SFD_HE_0P85)) begin
         if (ctrl_ff[SFD_CTRL_IO_BIT] ||
             (bw != SFD_BW_NB && feat_i.longterm_snr > SFD_LT_25)) begin
            if (ho_len > SFD_HO_CAP_LO) ho_len = SFD_HO_CAP_LO;
         end else if (ho_len > SFD_HO_CAP_HI) begin
            ho_len = SFD_HO_CAP_HI;
         end
      end
      unique case (bw)
         SFD_BW_NB: dec = silence ? 4'h0 : 4'h1;
         SFD_BW_WB: dec = silence ? 4'h2 : 4'h3;
         default:   dec = silence ? 4'h2 : 4'h1;
      endcase
      ho_len = (ho_len > dec) ? ho_len - dec : 4'h0;
   end

   assign restart = (run_ff == SFD_RESTART_RUN) ||
                    (feat_i.final_active_count50 > SFD_C50_45);
   assign music_start = feat_i.primary_high_energy_activity > SFD_HE_0P98 &&
                        feat_i.frame_energy > SFD_ET_40 &&
                        feat_i.primary_active_count16 > SFD_C16_14 &&
                        feat_i.final_active_count50 > SFD_C50_48;
   assign cn_diff = (feat_i.cn_est_log > feat_i.cn_local_log) ?
                    feat_i.cn_est_log - feat_i.cn_local_log :
                    feat_i.cn_local_log - feat_i.cn_est_log;
   assign in_hang = !combined && (transmission_hangover_counter_ff != 4'h0 ||
                    music_hangover_counter_ff != 4'h0);
   assign cn_close = in_hang && (cn_diff < cn_tol_ff);
   assign tx_flag = combined || (in_hang && !cn_close && !ctrl_ff[SFD_CTRL_INIT_BIT]);

   // run of consecutive active primary frames, saturating at the restart length
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         run_ff <= 2'h0;
      end else if (frame_valid_i) begin
         if (!pf) run_ff <= 2'h0;
         else if (run_ff != SFD_RESTART_RUN) run_ff <= run_ff + 2'h1;
      end
   end

   // counters: init clears, active frames with restart reload transmission, hangover frames count music down; transmission down, general up if it is nonzero
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         general_hangover_counter_ff      <= 4'h0;
         transmission_hangover_counter_ff <= 4'h0;
         music_hangover_counter_ff        <= 4'h0;
         ho_len_ff                        <= 4'h0;
      end else if (frame_valid_i) begin
         if (ctrl_ff[SFD_CTRL_INIT_BIT]) begin
            general_hangover_counter_ff      <= 4'h0;
            transmission_hangover_counter_ff <= 4'h0;
            music_hangover_counter_ff        <= 4'h0;
         end else begin
            ho_len_ff <= ho_len;
            if (combined && restart) begin
               transmission_hangover_counter_ff <= ho_len;
               general_hangover_counter_ff      <= 4'h0;
            end else if (cn_close) begin
               transmission_hangover_counter_ff <= 4'h0;
            end else if (in_hang && transmission_hangover_counter_ff != 4'h0) begin
               transmission_hangover_counter_ff <= transmission_hangover_counter_ff - 4'h1;
               general_hangover_counter_ff <= general_hangover_counter_ff + 4'h1;
            end
            if (music_start) begin
               music_hangover_counter_ff <= SFD_MUSIC_LEN;
            end else if (cn_close) begin
               music_hangover_counter_ff <= 4'h0;
            end else if (!combined && music_hangover_counter_ff != 4'h0) begin
               music_hangover_counter_ff <= music_hangover_counter_ff - 4'h1;
            end
         end
      end
   end

   // registered results, held between strobes; descriptor request one frame late
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         res_o       <= '0;
         sid_pend_ff <= 1'b0;
      end else if (frame_valid_i) begin
         sid_pend_ff                      <= cn_close;
         res_o.combined_flag              <= combined;
         res_o.transmission_activity_flag <= tx_flag;
         res_o.early_termination_flag     <= cn_close;
         res_o.sid_request                <= sid_pend_ff && !tx_flag;
         res_o.noise_silence              <= silence;
      end
   end
endmodule // sfd_top
`default_nettype wire

// ---- src/sfd_pkg.sv ----
// Purpose: constants and carriers for the speech activity final decision block
// Assumes: snr-like inputs are unsigned fixed point with 4 fraction bits (q4)
// Notes:   activity fractions are q8 (256 = 1.0)
package sfd_pkg;
   // ************************************************************
   // register map (apb, byte addresses)
   // ************************************************************
   localparam logic [7:0]  SFD_CTRL_OFS    = 8'h00;
   localparam logic [7:0]  SFD_THR_OFS     = 8'h04;
   localparam logic [7:0]  SFD_STATUS_OFS  = 8'h08;
   localparam logic [7:0]  SFD_COUNT_OFS   = 8'h0c;
   localparam logic [7:0]  SFD_CNENERGY_OFS = 8'h10;
   localparam logic [7:0]  SFD_CTRL_RST    = 8'h00;
   localparam logic [15:0] SFD_THR1_RST    = 16'h00a0;
   localparam logic [15:0] SFD_THR2_RST    = 16'h00a0;
   localparam logic [15:0] SFD_CN_TOL_RST  = 16'h0010;
   // ctrl fields
   localparam int SFD_CTRL_RATE_LSB = 0;   // 2 bits
   localparam int SFD_CTRL_BW_LSB   = 2;   // 2 bits
   localparam int SFD_CTRL_IO_BIT   = 4;
   localparam int SFD_CTRL_INIT_BIT = 5;
   // ************************************************************
   // thresholds (q4 for snr, flux and energy; counts and lengths plain)
   // ************************************************************
   localparam logic [15:0] SFD_SNRF_0P2   = 16'h0003;
   localparam logic [15:0] SFD_LF_10P5    = 16'h00a8;
   localparam logic [15:0] SFD_LF_12P5    = 16'h00c8;
   localparam logic [15:0] SFD_FLUX_2P2   = 16'h0023;
   localparam logic [15:0] SFD_FLUX_2P0   = 16'h0020;
   localparam logic [15:0] SFD_FLUX_1P5   = 16'h0018;
   localparam logic [7:0]  SFD_CONT_40    = 8'h28;
   localparam logic [7:0]  SFD_CONT_30    = 8'h1e;
   localparam logic [15:0] SFD_LT_16      = 16'h0100;
   localparam logic [15:0] SFD_LT_25      = 16'h0190;
   localparam logic [15:0] SFD_ET_40      = 16'h0280;
   localparam logic [8:0]  SFD_HE_0P95    = 9'h0f3;
   localparam logic [8:0]  SFD_HE_0P85    = 9'h0d9;
   localparam logic [8:0]  SFD_HE_0P98    = 9'h0fa;
   localparam logic [4:0]  SFD_C16_12     = 5'h0c;
   localparam logic [4:0]  SFD_C16_7      = 5'h07;
   localparam logic [4:0]  SFD_C16_14     = 5'h0e;
   localparam logic [5:0]  SFD_C50_40     = 6'h28;
   localparam logic [5:0]  SFD_C50_45     = 6'h2d;
   localparam logic [5:0]  SFD_C50_48     = 6'h30;
   localparam logic [3:0]  SFD_HO_BASE    = 4'h2;
   localparam logic [3:0]  SFD_HO_BASE_NB = 4'h3;
   localparam logic [3:0]  SFD_HO_ADD16   = 4'h2;
   localparam logic [3:0]  SFD_HO_ADD50   = 4'h5;
   localparam logic [3:0]  SFD_HANGOVER_LONG = 4'ha;
   localparam logic [3:0]  SFD_HO_CAP_LO  = 4'h2;
   localparam logic [3:0]  SFD_HO_CAP_HI  = 4'h3;
   localparam logic [3:0]  SFD_MUSIC_LEN  = 4'hf;
   localparam logic [1:0]  SFD_RESTART_RUN = 2'h3;
   localparam int          SFD_FRAME_LEN  = 256;
   // ************************************************************
   // enumerations and carriers
   // ************************************************************
   typedef enum logic [1:0] {SFD_RATE_16K = 2'h0, SFD_RATE_32K = 2'h1,
                             SFD_RATE_OTHER = 2'h2} sfd_rate_t;
   typedef enum logic [1:0] {SFD_BW_NB = 2'h0, SFD_BW_WB = 2'h1,
                             SFD_BW_SWB = 2'h2} sfd_bw_t;
   typedef struct packed {
      logic        primary_activity_flag;
      logic        secondary_activity_flag;
      logic        tonal_flag;
      logic [15:0] original_longterm_snr;
      logic [15:0] smoothed_longterm_freq_snr;
      logic [15:0] freq_snr;
      logic [15:0] avg_snr_flux;
      logic [7:0]  consecutive_active_count;
      logic [15:0] longterm_snr;
      logic [8:0]  primary_high_energy_activity;
      logic [4:0]  primary_active_count16;
      logic [5:0]  final_active_count50;
      logic [15:0] frame_energy;
      logic [15:0] cn_est_log;
      logic [15:0] cn_local_log;
   } sfd_feat_t;
   typedef struct packed {
      logic combined_flag;
      logic transmission_activity_flag;
      logic early_termination_flag;
      logic sid_request;
      logic noise_silence;
   } sfd_res_t;
endpackage

// ---- dv/sfd_monitor.sv ----
// Purpose: port-level checks of the final decision block
// Assumes: one clock, reset_i asynchronous and active high
// Notes:   hangover lengths are judged by the bench, not here
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// checker
// ************************************************************
module sfd_monitor
   import sfd_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        frame_valid_i,
   input wire sfd_feat_t   feat_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire sfd_res_t    res_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // tonal frame that came out non-silent
   sequence s_tonal_frame;
      frame_valid_i && feat_i.tonal_flag ##1 !res_o.noise_silence;
   endsequence
   // access phase still waiting for the slave
   sequence s_wait;
      psel_i && penable_i && !pready_o;
   endsequence
   a_zero_snr_noisy:
      assert property (frame_valid_i && feat_i.original_longterm_snr == '0 |=> !res_o.noise_silence)
      else $error("silence flagged at zero long-time snr");
   a_equal_flags_pass:
      assert property (frame_valid_i && feat_i.primary_activity_flag == feat_i.secondary_activity_flag
         |=> res_o.combined_flag == $past(feat_i.primary_activity_flag))
      else $error("agreeing detector flags not passed through");
   a_tonal_or_flags:
      assert property (s_tonal_frame |-> res_o.combined_flag ==
         $past(feat_i.primary_activity_flag | feat_i.secondary_activity_flag))
      else $error("tonal non-silent frame did not or the flags");
   a_held_between:
      assert property (!frame_valid_i |=> $stable(res_o))
      else $error("result changed without a frame strobe");
   a_dtx_covers_active:
      assert property (res_o.combined_flag |-> res_o.transmission_activity_flag)
      else $error("active frame not active for transmission");
   a_sid_after_term:
      assert property ($rose(res_o.sid_request) |-> $past(res_o.early_termination_flag))
      else $error("descriptor request without earlier termination");
   a_one_wait_state:
      assert property (s_wait |=> pready_o)
      else $error("ready not given after one wait state");
   a_ready_in_access:
      assert property (pready_o |-> psel_i && penable_i)
      else $error("ready outside an access phase");
   a_unmapped_error:
      assert property (pready_o && paddr_i > 8'h10 |-> pslverr_o && (pwrite_i || prdata_o == '0))
      else $error("unmapped access not refused");
endmodule // sfd_monitor
bind sfd_top sfd_monitor sfd_monitor_i (.clk_i, .reset_i, .frame_valid_i, .feat_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .res_o);
`default_nettype wire

// ---- dv/sfd_feat_model.sv ----
// Purpose: upstream feature and excitation source of the decision block
// Assumes: the bench sets feat_i and amp_i before it raises go_i
// Notes:   fields are inverted off the strobe so stale sampling shows up
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// feature source
// ************************************************************
module sfd_feat_model
   import sfd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        go_i,
   input  wire sfd_feat_t   feat_i,
   input  wire logic [15:0] amp_i,
   output logic             frame_valid_o,
   output sfd_feat_t        feat_o,
   output logic             exc_valid_o,
   output logic [15:0]      exc_sample_o
);
   logic [8:0] cnt_ff;
   // one frame is 256 samples, then a single strobe
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_ff <= 9'h000;
      end else if (cnt_ff != 9'h000) begin
         cnt_ff <= cnt_ff - 9'h001;
      end else if (go_i) begin
         cnt_ff <= 9'h101;
      end
   end
   // no valid data outside its qualifier
   assign exc_valid_o   = cnt_ff > 9'h001;
   assign exc_sample_o  = exc_valid_o ? amp_i : ~amp_i;
   assign frame_valid_o = cnt_ff == 9'h001;
   assign feat_o        = frame_valid_o ? feat_i : ~feat_i;
endmodule // sfd_feat_model
`default_nettype wire

// ---- dv/test_speech_activity_final_decision.sv ----
// Purpose: self-checking bench of the final decision block
// Assumes: thresholds stay at reset values for the decision cases
// Notes:   hangover lengths are worked out from the package constants
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// bench top
// ************************************************************
module test_speech_activity_final_decision
   import sfd_pkg::*;
;
   logic        clk_i, reset_i = 1'b1, go = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pready, pslverr, er, frame_valid, exc_valid;
   logic [7:0]  paddr = 8'h00;
   logic [15:0] amp = 16'h0010, exc_sample;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   sfd_feat_t   feat = '0, feat_d, f, a;
   sfd_res_t    res;
   int          err_count = 0, checks_done = 0;
   sfd_feat_model sfd_feat_model_i (.clk_i, .reset_i, .go_i(go), .feat_i(feat), .amp_i(amp),
      .frame_valid_o(frame_valid), .feat_o(feat_d), .exc_valid_o(exc_valid),
      .exc_sample_o(exc_sample));
   sfd_top sfd_top_i (.clk_i, .reset_i, .frame_valid_i(frame_valid), .feat_i(feat_d),
      .exc_valid_i(exc_valid), .exc_sample_i(exc_sample), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .res_o(res));
   // 125 mhz clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until ready; result left in rd and er
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one frame through the source; result settled on return
   task automatic frame(input sfd_feat_t fv);
      int n = 0;
      @(posedge clk_i);
      feat <= fv;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      do @(posedge clk_i); while (frame_valid !== 1'b1 && ++n < 400);
      if (n >= 400) err_count++;
      @(negedge clk_i);
   endtask
   task automatic dec_case(input logic [1:0] rate, input logic [2:0] pst, input logic q,
                           input logic [15:0] sm, sf, fx, input logic [7:0] ct, input logic e);
      apb(1'b1, SFD_CTRL_OFS, {30'h0, rate});
      f = '0;
      {f.primary_activity_flag, f.secondary_activity_flag, f.tonal_flag} = pst;
      f.original_longterm_snr = q ? 16'h0200 : 16'h0000;
      f.smoothed_longterm_freq_snr = sm;
      f.freq_snr = sf;
      f.avg_snr_flux = fx;
      f.consecutive_active_count = ct;
      frame(f);
      check({31'h0, res.combined_flag}, {31'h0, e});
      check({31'h0, res.noise_silence}, {31'h0, q && sm > SFD_THR2_RST});
   endtask
   task automatic set_act(input logic [8:0] he, input logic [4:0] c16, input logic [5:0] c50,
                          input logic [15:0] en);
      a = '0;
      {a.primary_activity_flag, a.secondary_activity_flag} = 2'b11;
      a.primary_high_energy_activity = he;
      a.primary_active_count16 = c16;
      a.final_active_count50 = c50;
      a.frame_energy = en;
   endtask
   // a run past the restart length reloads, quiet frames run it out
   task automatic ho_run(input logic [31:0] ctrl, input logic q, input logic [15:0] est,
                         input logic [7:0] nho);
      apb(1'b1, SFD_CTRL_OFS, ctrl);
      a.original_longterm_snr = q ? 16'h0200 : 16'h0000;
      a.smoothed_longterm_freq_snr = a.original_longterm_snr;
      a.cn_local_log = 16'h0100;
      repeat (4) frame(a);
      f = a;
      {f.primary_activity_flag, f.secondary_activity_flag} = 2'b00;
      f.primary_high_energy_activity = '0;
      f.frame_energy = '0;
      f.cn_est_log = est;
      for (int i = 0; i <= nho; i++) begin
         frame(f);
         check({31'h0, res.transmission_activity_flag}, {31'h0, i < nho});
      end
   endtask
   task automatic t_regs();
      apb(1'b0, SFD_CTRL_OFS, 32'h0);
      check(rd, {24'h0, SFD_CTRL_RST});
      apb(1'b0, SFD_THR_OFS, 32'h0);
      check(rd, {SFD_THR2_RST, SFD_THR1_RST});
      apb(1'b0, SFD_COUNT_OFS, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, SFD_CNENERGY_OFS, 32'h0);
      check({16'h0, rd[31:16]}, {16'h0, SFD_CN_TOL_RST});
      apb(1'b1, 8'h20, 32'hffffffff);
      apb(1'b0, 8'h20, 32'h0);
      check({rd[30:0], er}, 32'h1);
      $display("test regs done");
   endtask
   task automatic t_decide();
      dec_case(2'h0, 3'h4, 1'b1, 16'h0200, 16'h0010, 16'h0000, 8'h00, 1'b1);
      dec_case(2'h0, 3'h2, 1'b1, 16'h00b0, 16'h0000, 16'h0000, 8'h00, 1'b1);
      dec_case(2'h0, 3'h2, 1'b0, 16'h0000, 16'h0000, 16'h0024, 8'h00, 1'b1);
      dec_case(2'h0, 3'h2, 1'b0, 16'h0000, 16'h0000, 16'h0023, 8'h00, 1'b0);
      dec_case(2'h0, 3'h2, 1'b0, 16'h0000, 16'h0000, 16'h0019, 8'h29, 1'b1);
      dec_case(2'h0, 3'h2, 1'b0, 16'h0000, 16'h0000, 16'h0019, 8'h28, 1'b0);
      dec_case(2'h0, 3'h3, 1'b0, 16'h0000, 16'h0000, 16'h0000, 8'h00, 1'b1);
      dec_case(2'h1, 3'h2, 1'b0, 16'h0000, 16'h0000, 16'h0000, 8'h00, 1'b1);
      dec_case(2'h1, 3'h2, 1'b1, 16'h00a4, 16'h0000, 16'h0000, 8'h00, 1'b0);
      dec_case(2'h2, 3'h2, 1'b1, 16'h00c9, 16'h0000, 16'h0000, 8'h00, 1'b0);
      dec_case(2'h2, 3'h2, 1'b1, 16'h00c8, 16'h0000, 16'h0000, 8'h00, 1'b1);
      dec_case(2'h2, 3'h3, 1'b1, 16'h00c9, 16'h0000, 16'h0000, 8'h00, 1'b1);
      dec_case(2'h2, 3'h4, 1'b0, 16'h0000, 16'h0000, 16'h0021, 8'h00, 1'b1);
      dec_case(2'h2, 3'h4, 1'b0, 16'h0000, 16'h0000, 16'h0020, 8'h00, 1'b0);
      dec_case(2'h2, 3'h4, 1'b0, 16'h0000, 16'h0000, 16'h0019, 8'h1f, 1'b1);
      $display("test decide done");
   endtask
   task automatic t_hang();
      set_act(9'h000, 5'h00, 6'h00, 16'h0000);
      ho_run(32'h00, 1'b1, 16'h0000, 8'h03);
      ho_run(32'h04, 1'b0, 16'h0000, 8'h00);
      ho_run(32'h10, 1'b1, 16'h0000, 8'h02);
      set_act(9'h000, 5'h0d, 6'h00, 16'h0000);
      ho_run(32'h00, 1'b1, 16'h0000, 8'h05);
      set_act(9'h000, 5'h0d, 6'h29, 16'h0000);
      ho_run(32'h00, 1'b1, 16'h0000, 8'h09);
      set_act(9'h0fb, 5'h0f, 6'h31, 16'h0290);
      ho_run(32'h00, 1'b1, 16'h0000, 8'h0f);
      $display("test hangover done");
   endtask
   task automatic t_term();
      set_act(9'h000, 5'h00, 6'h00, 16'h0000);
      ho_run(32'h00, 1'b1, 16'h0100, 8'h00);
      check({31'h0, res.early_termination_flag}, 32'h1);
      frame(f);
      check({31'h0, res.sid_request}, 32'h1);
      $display("test termination done");
   endtask
   // counters cleared by init, then excitation energy of a known level
   task automatic t_init();
      set_act(9'h0fb, 5'h0f, 6'h31, 16'h0290);
      repeat (3) frame(a);
      apb(1'b1, SFD_CTRL_OFS, 32'h20);
      amp <= 16'h0040;
      frame('{cn_local_log: 16'h0100, default: '0});
      check({31'h0, res.transmission_activity_flag}, 32'h0);
      apb(1'b0, SFD_COUNT_OFS, 32'h0);
      check({20'h0, rd[11:0]}, 32'h0);
      apb(1'b0, SFD_CNENERGY_OFS, 32'h0);
      check({16'h0, rd[15:0]}, 32'h000000c0);
      $display("test init and energy done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // main sequence after 16 cycles of reset
   initial begin
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      t_regs();
      t_decide();
      t_hang();
      t_term();
      t_init();
      complete_run();
   end
   // watchdog, far beyond about a hundred frames
   initial begin
      #600000;
      err_count++;
      complete_run();
   end
endmodule // test_speech_activity_final_decision
`default_nettype wire
